//--- src/mdc_pkg.sv
package mdc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int TEMP_W = 16;
    localparam int CODE_W = 10;

    // Register offsets
    localparam logic [7:0] OFS_FS_LOW = 8'h18;
    localparam logic [7:0] OFS_FS_HIGH = 8'h19;
    localparam logic [7:0] OFS_TEMP_SETUP = 8'h1c;
    localparam logic [7:0] OFS_TEMP_LOW = 8'h1d;
    localparam logic [7:0] OFS_TEMP_HIGH = 8'h1e;
    localparam logic [7:0] OFS_PART_ID = 8'h1f;
    localparam logic [7:0] OFS_IRQ = 8'h20;
    localparam logic [7:0] OFS_ALIGN = 8'h21;
    localparam logic [7:0] OFS_FRAME = 8'h22;

    // Reset values
    localparam logic [7:0] RST_FS_LOW = 8'hf9;
    localparam logic [7:0] RST_FS_HIGH = 8'he1;
    localparam logic [7:0] RST_TEMP_SETUP = 8'h02;
    localparam logic [15:0] RST_TEMP = 16'h0000;
    localparam logic [7:0] RST_IRQ = 8'h00;
    localparam logic [7:0] RST_ALIGN = 8'h00;
    localparam logic [7:0] RST_FRAME = 8'h12;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // Writable bits; the others read back their reset value
    localparam logic [7:0] WMASK_FS_HIGH = 8'he3;
    localparam logic [7:0] WMASK_TEMP_SETUP = 8'h7f;
    localparam logic [7:0] WMASK_ALIGN = 8'h03;
    localparam logic [7:0] WMASK_FRAME = 8'h0f;

    // Field positions
    localparam int FS_HIGH_MSB = 1;
    localparam int BANDGAP_TRIM_MSB = 7;
    localparam int BANDGAP_TRIM_LSB = 5;
    localparam int TS_RANGE_MSB = 6;
    localparam int TS_RANGE_LSB = 4;
    localparam int TS_REF_MSB = 3;
    localparam int TS_REF_LSB = 1;
    localparam int TS_POWER_BIT = 0;
    localparam int ALIGN_EN_BIT = 0;
    localparam int ALIGN_EDGE_BIT = 1;
    localparam int FRAME_ARM_BIT = 3;
    localparam int FRAME_REPEAT_BIT = 2;
    localparam int FRAME_TGT_MSB = 1;

    localparam logic [1:0] TGT_FIFO = 2'h2;
    localparam logic [1:0] TGT_NONE = 2'h3;
    localparam logic [7:0] IRQ_TEST = 8'h00;
    localparam logic [7:0] IRQ_NORMAL = 8'h01;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mdc_reg_req_type;

    typedef struct packed {
        logic [CODE_W-1:0] fs_code;
        logic [2:0] bandgap_trim_code;
        logic [2:0] thermal_adc_range_current;
        logic [2:0] thermal_ref_current;
        logic thermal_power;
        logic [7:0] irq_mode_value;
        logic irq_normal;
        logic align_enable;
        logic align_falling_edge;
    } mdc_cfg_type;

    typedef enum logic [1:0] {
        FR_ARMED = 2'b01,
        FR_SPENT = 2'b10
    } mdc_frame_state_type;

endpackage

//--- src/mdc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module mdc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    // First stage is read only by the second stage
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta;
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta <= 1'b0;
                    q_o[gi] <= 1'b0;
                end else begin
                    meta <= d_i[gi];
                    q_o[gi] <= meta;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

//--- src/mdc_frame_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module mdc_frame_ctl
    import mdc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic frame_pulse_i,
    input wire logic repeat_i,
    input wire logic [1:0] target_i,
    input wire logic rearm_i,
    output logic fifo_reset_o,
    output logic armed_o
);
    mdc_frame_state_type state, next_state;
    logic next_fifo_reset;
    logic act;

    // Continuous mode answers every pulse; one-shot only while armed
    assign act = frame_pulse_i && (state == FR_ARMED || repeat_i);
    assign armed_o = (state == FR_ARMED);

    always_comb begin
        next_state = state;
        // Reserved targets 00 and 01 reset nothing
        next_fifo_reset = act && (target_i == TGT_FIFO);
        case (state)
            FR_ARMED: begin
                if (act && !repeat_i && !rearm_i) begin
                    next_state = FR_SPENT;
                end
            end
            FR_SPENT: begin
                if (rearm_i) begin
                    next_state = FR_ARMED;
                end
            end
            default: next_state = FR_ARMED;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= FR_ARMED;
            fifo_reset_o <= 1'b0;
        end else begin
            state <= next_state;
            fifo_reset_o <= next_fifo_reset;
        end
    end

    spent_no_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state == FR_SPENT && !repeat_i) |=> !fifo_reset_o)
        else $error("fifo reset issued while one-shot spent");
    repeat_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (frame_pulse_i && repeat_i && target_i == TGT_FIFO) |=> fifo_reset_o)
        else $error("continuous mode missed a frame pulse");
    rearm_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rearm_i |=> state == FR_ARMED)
        else $error("rearm did not arm the frame logic");
    none_target_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (target_i != TGT_FIFO) |=> !fifo_reset_o)
        else $error("fifo reset with non-fifo target");
endmodule
`default_nettype wire

//--- src/mdc_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Full-scale code high bits from high register
// - Full-scale low byte register, resets 0xF9
// - Bandgap trim bits 7:5, resets all ones
// - Sensor range current bits 6:4, resets zero
// - Sensor reference current bits 3:1, resets one
// - Sensor powered only while enable bit set
// - 16-bit temperature readback, low then high
// - Interrupt mode: zero test, one normal
// - Sync enable bit 0, edge select bit 1
// - Arm write re-enables one-shot frame reset
// - One-shot mode: first frame pulse only
// - Continuous mode: every frame pulse resets
// - Target code 10 FIFO, 11 nothing
module mdc_regs
    import mdc_pkg::*;
#(
    // Arbitrary value, not tied to any real part
    parameter logic [7:0] PART_CODE = 8'h5c
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire mdc_reg_req_type reg_req_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic [TEMP_W-1:0] temp_value_i,
    input wire logic temp_valid_i,
    input wire logic frame_i,
    output mdc_cfg_type cfg_o,
    output logic fifo_reset_o,
    output logic frame_armed_o
);
    logic [1:0] rst_pipe;
    logic rst_n;
    logic [7:0] fs_low, next_fs_low;
    logic [7:0] fs_high, next_fs_high;
    logic [7:0] temp_setup, next_temp_setup;
    logic [TEMP_W-1:0] temp_val, next_temp_val;
    logic [7:0] temp_high_hold, next_temp_high_hold;
    logic [7:0] irq_mode, next_irq_mode;
    logic [7:0] align_ctl, next_align_ctl;
    logic [7:0] frame_ctl, next_frame_ctl;
    logic [7:0] next_rdata;
    logic rearm;
    logic frame_sync;
    logic frame_prev;
    logic frame_pulse;
    logic wr_fs_low, wr_fs_high, wr_temp_setup, wr_irq, wr_align, wr_frame;

    // Reset released through two flops so release is glitch free in this domain
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // Write decode
    always_comb begin
        wr_fs_low = 1'b0;
        wr_fs_high = 1'b0;
        wr_temp_setup = 1'b0;
        wr_irq = 1'b0;
        wr_align = 1'b0;
        wr_frame = 1'b0;
        if (!reg_req_i.wr) begin
            wr_fs_low = 1'b0;
        end else if (reg_req_i.addr == OFS_FS_LOW) begin
            wr_fs_low = 1'b1;
        end else if (reg_req_i.addr == OFS_FS_HIGH) begin
            wr_fs_high = 1'b1;
        end else if (reg_req_i.addr == OFS_TEMP_SETUP) begin
            wr_temp_setup = 1'b1;
        end else if (reg_req_i.addr == OFS_IRQ) begin
            wr_irq = 1'b1;
        end else if (reg_req_i.addr == OFS_ALIGN) begin
            wr_align = 1'b1;
        end else if (reg_req_i.addr == OFS_FRAME) begin
            wr_frame = 1'b1;
        end
    end

    // Only a written one rearms; writing zero leaves the one-shot state alone
    assign rearm = wr_frame && reg_req_i.wdata[FRAME_ARM_BIT];

    // Register next values
    always_comb begin
        next_fs_low = fs_low;
        next_fs_high = fs_high;
        next_temp_setup = temp_setup;
        next_irq_mode = irq_mode;
        next_align_ctl = align_ctl;
        next_frame_ctl = frame_ctl;
        next_temp_val = temp_val;
        next_temp_high_hold = temp_high_hold;
        if (wr_fs_low) begin
            next_fs_low = reg_req_i.wdata;
        end
        if (wr_fs_high) begin
            next_fs_high = (reg_req_i.wdata & WMASK_FS_HIGH) | (RST_FS_HIGH & ~WMASK_FS_HIGH);
        end
        if (wr_temp_setup) begin
            next_temp_setup = (reg_req_i.wdata & WMASK_TEMP_SETUP)
                | (RST_TEMP_SETUP & ~WMASK_TEMP_SETUP);
        end
        if (wr_irq) begin
            next_irq_mode = reg_req_i.wdata;
        end
        if (wr_align) begin
            next_align_ctl = (reg_req_i.wdata & WMASK_ALIGN) | (RST_ALIGN & ~WMASK_ALIGN);
        end
        if (wr_frame) begin
            next_frame_ctl = (reg_req_i.wdata & WMASK_FRAME) | (RST_FRAME & ~WMASK_FRAME);
        end
        // A powered-down sensor produces no samples worth keeping
        if (temp_valid_i && temp_setup[TS_POWER_BIT]) begin
            next_temp_val = temp_value_i;
        end
        // Reading the low byte freezes the high byte so the pair is coherent
        if (reg_req_i.rd && reg_req_i.addr == OFS_TEMP_LOW) begin
            // Snapshot the same sample whose low byte this read returns
            next_temp_high_hold = temp_val[TEMP_W-1:DATA_W];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            fs_low <= RST_FS_LOW;
            fs_high <= RST_FS_HIGH;
            temp_setup <= RST_TEMP_SETUP;
            temp_val <= RST_TEMP;
            temp_high_hold <= RST_TEMP[TEMP_W-1:DATA_W];
            irq_mode <= RST_IRQ;
            align_ctl <= RST_ALIGN;
            frame_ctl <= RST_FRAME;
        end else begin
            fs_low <= next_fs_low;
            fs_high <= next_fs_high;
            temp_setup <= next_temp_setup;
            temp_val <= next_temp_val;
            temp_high_hold <= next_temp_high_hold;
            irq_mode <= next_irq_mode;
            align_ctl <= next_align_ctl;
            frame_ctl <= next_frame_ctl;
        end
    end

    // Read data, returned one cycle after the strobe; unmapped reads give zero
    always_comb begin
        next_rdata = RD_UNMAPPED;
        if (reg_req_i.addr == OFS_FS_LOW) begin
            next_rdata = fs_low;
        end else if (reg_req_i.addr == OFS_FS_HIGH) begin
            next_rdata = fs_high;
        end else if (reg_req_i.addr == OFS_TEMP_SETUP) begin
            next_rdata = temp_setup;
        end else if (reg_req_i.addr == OFS_TEMP_LOW) begin
            next_rdata = temp_val[DATA_W-1:0];
        end else if (reg_req_i.addr == OFS_TEMP_HIGH) begin
            next_rdata = temp_high_hold;
        end else if (reg_req_i.addr == OFS_PART_ID) begin
            next_rdata = PART_CODE;
        end else if (reg_req_i.addr == OFS_IRQ) begin
            next_rdata = irq_mode;
        end else if (reg_req_i.addr == OFS_ALIGN) begin
            next_rdata = align_ctl;
        end else if (reg_req_i.addr == OFS_FRAME) begin
            next_rdata = frame_ctl;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= RD_UNMAPPED;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_req_i.rd;
            if (reg_req_i.rd) begin
                reg_rdata_o <= next_rdata;
            end
        end
    end

    // Settings leave the block straight from their flops, except irq_normal, decoded from irq_mode
    assign cfg_o.fs_code = {fs_high[FS_HIGH_MSB:0], fs_low};
    assign cfg_o.bandgap_trim_code = fs_high[BANDGAP_TRIM_MSB:BANDGAP_TRIM_LSB];
    assign cfg_o.thermal_adc_range_current = temp_setup[TS_RANGE_MSB:TS_RANGE_LSB];
    assign cfg_o.thermal_ref_current = temp_setup[TS_REF_MSB:TS_REF_LSB];
    assign cfg_o.thermal_power = temp_setup[TS_POWER_BIT];
    assign cfg_o.irq_mode_value = irq_mode;
    assign cfg_o.irq_normal = (irq_mode == IRQ_NORMAL);
    assign cfg_o.align_enable = align_ctl[ALIGN_EN_BIT];
    assign cfg_o.align_falling_edge = align_ctl[ALIGN_EDGE_BIT];

    // Frame pin comes from outside this clock
    mdc_sync #(
        .WIDTH(1)
    ) u_frame_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .d_i(frame_i),
        .q_o(frame_sync)
    );

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            frame_prev <= 1'b0;
        end else begin
            frame_prev <= frame_sync;
        end
    end
    assign frame_pulse = frame_sync && !frame_prev;

    mdc_frame_ctl u_frame_ctl (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .frame_pulse_i(frame_pulse),
        .repeat_i(frame_ctl[FRAME_REPEAT_BIT]),
        .target_i(frame_ctl[FRAME_TGT_MSB:0]),
        .rearm_i(rearm),
        .fifo_reset_o(fifo_reset_o),
        .armed_o(frame_armed_o)
    );

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    fs_low_write_a: assert property (wr_fs_low |=> cfg_o.fs_code[7:0] == $past(reg_req_i.wdata))
        else $error("full-scale low byte not updated");
    fs_high_write_a: assert property (wr_fs_high
        |=> cfg_o.fs_code[9:8] == $past(reg_req_i.wdata[FS_HIGH_MSB:0])
            && cfg_o.bandgap_trim_code
                == $past(reg_req_i.wdata[BANDGAP_TRIM_MSB:BANDGAP_TRIM_LSB]))
        else $error("full-scale high or trim not updated");
    part_code_read_a: assert property ((reg_req_i.rd && reg_req_i.addr == OFS_PART_ID)
        |=> reg_rvalid_o && reg_rdata_o == PART_CODE)
        else $error("part code read wrong");
    sensor_off_hold_a: assert property (!cfg_o.thermal_power |=> $stable(temp_val))
        else $error("temperature captured while sensor off");
    temp_pair_read_a: assert property ((reg_req_i.rd && reg_req_i.addr == OFS_TEMP_LOW)
        |=> reg_rdata_o == $past(temp_val[7:0]))
        else $error("temperature low byte read wrong");
    irq_mode_flag_a: assert property (wr_irq && reg_req_i.wdata == IRQ_NORMAL
        |=> cfg_o.irq_normal ##1 cfg_o.irq_normal || $past(wr_irq))
        else $error("interrupt normal mode not reported");
    align_write_a: assert property (wr_align
        |=> cfg_o.align_enable == $past(reg_req_i.wdata[0])
            && cfg_o.align_falling_edge == $past(reg_req_i.wdata[1]))
        else $error("sync control not applied");
    sensor_setup_a: assert property (wr_temp_setup
        |=> cfg_o.thermal_adc_range_current == $past(reg_req_i.wdata[6:4])
            && cfg_o.thermal_ref_current == $past(reg_req_i.wdata[3:1]))
        else $error("sensor current selects not applied");

    // Registers without a write this cycle keep their contents; sensor enable and interrupt value writes are applied
    fs_low_keep_a: assert property (!wr_fs_low |=> $stable(fs_low))
        else $error("full-scale low byte changed without a write");
    fs_high_keep_a: assert property (!wr_fs_high |=> $stable(fs_high))
        else $error("full-scale high register changed without a write");
    setup_keep_a: assert property (!wr_temp_setup |=> $stable(temp_setup))
        else $error("sensor setup changed without a write");
    align_keep_a: assert property (!wr_align |=> $stable(align_ctl))
        else $error("sync control changed without a write");
    sensor_power_a: assert property (wr_temp_setup
        |=> cfg_o.thermal_power == $past(reg_req_i.wdata[TS_POWER_BIT]))
        else $error("sensor enable not applied");
    irq_value_a: assert property (wr_irq
        |=> cfg_o.irq_mode_value == $past(reg_req_i.wdata))
        else $error("interrupt mode value not stored");

    // Temperature capture and the coherent pair
    temp_capture_a: assert property ((temp_valid_i && cfg_o.thermal_power)
        |=> temp_val == $past(temp_value_i))
        else $error("temperature sample not captured");
    temp_hold_a: assert property (!(temp_valid_i && cfg_o.thermal_power)
        |=> $stable(temp_val))
        else $error("temperature changed without a sample");
    temp_snapshot_a: assert property ((reg_req_i.rd && reg_req_i.addr == OFS_TEMP_LOW)
        |=> temp_high_hold == $past(temp_val[TEMP_W-1:DATA_W]))
        else $error("high byte snapshot not from the read sample");
    temp_high_read_a: assert property ((reg_req_i.rd && reg_req_i.addr == OFS_TEMP_HIGH)
        |=> reg_rdata_o == $past(temp_high_hold))
        else $error("temperature high byte read wrong");

    // Frame path: one internal pulse per rising pin edge, resets only on pulses
    frame_edge_once_a: assert property (frame_pulse |=> !frame_pulse)
        else $error("frame edge held longer than one cycle");
    frame_reset_cause_a: assert property (fifo_reset_o |-> $past(frame_pulse))
        else $error("fifo reset without a frame pulse");
    rearm_arms_a: assert property (rearm |=> frame_armed_o)
        else $error("arm write left the one-shot logic spent");
    frame_write_a: assert property (wr_frame
        |=> frame_ctl[FRAME_TGT_MSB:0] == $past(reg_req_i.wdata[FRAME_TGT_MSB:0])
            && frame_ctl[FRAME_REPEAT_BIT] == $past(reg_req_i.wdata[FRAME_REPEAT_BIT]))
        else $error("frame control not stored");
endmodule
`default_nettype wire

//--- src/mdc_regs_placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mdc_pkg::*;

    // Arbitrary value, not tied to any real part
    localparam logic [7:0] TB_PART_CODE = 8'h3b;

    logic clk_i;
    logic rst_n_i;
    mdc_reg_req_type reg_req_i;
    logic [DATA_W-1:0] reg_rdata_o;
    logic reg_rvalid_o;
    logic [TEMP_W-1:0] temp_value_i;
    logic temp_valid_i;
    logic frame_i;
    mdc_cfg_type cfg_o;
    logic fifo_reset_o;
    logic frame_armed_o;
    int fails;
    int checks;
    int n;

    mdc_regs #(.PART_CODE(TB_PART_CODE)) u_mdc_regs (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .reg_req_i(reg_req_i),
        .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o),
        .temp_value_i(temp_value_i),
        .temp_valid_i(temp_valid_i),
        .frame_i(frame_i),
        .cfg_o(cfg_o),
        .fifo_reset_o(fifo_reset_o),
        .frame_armed_o(frame_armed_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_i);
        reg_req_i = '0;
    endtask

    // Answer lands on the edge after the request, so the next falling edge sees it settled
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_i);
        reg_req_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_i);
        reg_req_i = '0;
        check({15'h0000, reg_rvalid_o}, 16'h0001, "read valid");
        check({8'h00, reg_rdata_o}, {8'h00, exp}, $sformatf("read of %h", a));
        @(negedge clk_i);
        check({15'h0000, reg_rvalid_o}, 16'h0000, "valid lasts one cycle");
    endtask

    // Pin pulse held high four cycles, then low eight; resets counted over a bounded span
    task automatic frame_pulse(output int cnt);
        cnt = 0;
        @(negedge clk_i);
        frame_i = 1'b1;
        for (int i = 0; i < 12; i++) begin
            @(negedge clk_i);
            if (i == 3) begin
                frame_i = 1'b0;
            end
            if (fifo_reset_o === 1'b1) begin
                cnt++;
            end
        end
    endtask

    task automatic temp_sample(input logic [15:0] v);
        @(negedge clk_i);
        temp_value_i = v;
        temp_valid_i = 1'b1;
        @(negedge clk_i);
        temp_valid_i = 1'b0;
        temp_value_i = ~v;
    endtask

    logic [7:0] rst_addr [9] = '{8'h18, 8'h19, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22};
    logic [7:0] rst_val [9] = '{8'hf9, 8'he1, 8'h02, 8'h00, 8'h00, TB_PART_CODE, 8'h00, 8'h00,
        8'h12};

    initial begin
        fails = 0;
        checks = 0;
        rst_n_i = 1'b0;
        reg_req_i = '0;
        temp_value_i = 16'h0000;
        temp_valid_i = 1'b0;
        frame_i = 1'b0;
        repeat (10) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);

        for (int i = 0; i < 9; i++) begin
            rd_check(rst_addr[i], rst_val[i]);
        end
        check({6'h00, cfg_o.fs_code}, 16'h01f9, "default full-scale code");
        check({13'h0000, cfg_o.bandgap_trim_code}, 16'h0007, "trim default");
        check({13'h0000, cfg_o.thermal_adc_range_current}, 16'h0000, "range default");
        check({13'h0000, cfg_o.thermal_ref_current}, 16'h0001, "ref default");
        check({15'h0000, cfg_o.thermal_power}, 16'h0000, "sensor off");
        check({15'h0000, frame_armed_o}, 16'h0001, "armed after reset");
        rd_check(8'h40, RD_UNMAPPED);
        $display("test reset values done");

        reg_write(8'h19, 8'hff);
        reg_write(8'h18, 8'h5a);
        rd_check(8'h19, 8'he3);
        check({6'h00, cfg_o.fs_code}, 16'h035a, "full-scale code");
        check({13'h0000, cfg_o.bandgap_trim_code}, 16'h0007, "trim written");
        reg_write(8'h19, 8'h02);
        check({6'h00, cfg_o.fs_code}, 16'h025a, "high bits only");
        check({13'h0000, cfg_o.bandgap_trim_code}, 16'h0000, "trim cleared");
        reg_write(8'h1c, 8'h70);
        rd_check(8'h1c, 8'h70);
        check({13'h0000, cfg_o.thermal_adc_range_current}, 16'h0007, "range max");
        check({13'h0000, cfg_o.thermal_ref_current}, 16'h0000, "ref zero");
        reg_write(8'h1f, 8'h77);
        reg_write(8'h1d, 8'h55);
        reg_write(8'h1e, 8'h66);
        rd_check(8'h1f, TB_PART_CODE);
        rd_check(8'h1d, 8'h00);
        rd_check(8'h1e, 8'h00);
        $display("test write and read-only done");

        temp_sample(16'hbeef);
        rd_check(8'h1d, 8'h00);
        reg_write(8'h1c, 8'h0f);
        check({15'h0000, cfg_o.thermal_power}, 16'h0001, "sensor on");
        check({13'h0000, cfg_o.thermal_ref_current}, 16'h0007, "ref max");
        temp_sample(16'h1234);
        rd_check(8'h1d, 8'h34);
        temp_sample(16'h5678);
        rd_check(8'h1e, 8'h12);
        rd_check(8'h1d, 8'h78);
        rd_check(8'h1e, 8'h56);
        // Low-byte read in the same cycle as a new sample keeps the pair coherent
        @(negedge clk_i);
        temp_value_i = 16'habcd;
        temp_valid_i = 1'b1;
        reg_req_i = '{wr: 1'b0, rd: 1'b1, addr: 8'h1d, wdata: 8'h00};
        @(negedge clk_i);
        temp_valid_i = 1'b0;
        reg_req_i = '0;
        check({15'h0000, reg_rvalid_o}, 16'h0001, "read valid beside sample");
        check({8'h00, reg_rdata_o}, 16'h0078, "low read beside sample");
        rd_check(8'h1e, 8'h56);
        rd_check(8'h1d, 8'hcd);
        rd_check(8'h1e, 8'hab);
        $display("test temperature done");

        reg_write(8'h20, IRQ_NORMAL);
        check({15'h0000, cfg_o.irq_normal}, 16'h0001, "irq normal mode");
        check({8'h00, cfg_o.irq_mode_value}, 16'h0001, "irq value");
        reg_write(8'h20, IRQ_TEST);
        check({15'h0000, cfg_o.irq_normal}, 16'h0000, "irq test mode");
        reg_write(8'h21, 8'hff);
        rd_check(8'h21, 8'h03);
        check({14'h0000, cfg_o.align_falling_edge, cfg_o.align_enable}, 16'h0003, "sync on");
        reg_write(8'h21, 8'h02);
        check({14'h0000, cfg_o.align_falling_edge, cfg_o.align_enable}, 16'h0002, "edge only");
        $display("test irq and sync done");

        frame_pulse(n);
        check(n[15:0], 16'h0001, "first frame resets");
        check({15'h0000, frame_armed_o}, 16'h0000, "spent after pulse");
        frame_pulse(n);
        check(n[15:0], 16'h0000, "second frame ignored");
        reg_write(8'h22, 8'h0a);
        check({15'h0000, frame_armed_o}, 16'h0001, "rearmed");
        frame_pulse(n);
        check(n[15:0], 16'h0001, "rearmed frame resets");
        frame_pulse(n);
        check(n[15:0], 16'h0000, "single reset per arm");
        reg_write(8'h22, 8'h06);
        rd_check(8'h22, 8'h16);
        frame_pulse(n);
        check(n[15:0], 16'h0001, "continuous first");
        frame_pulse(n);
        check(n[15:0], 16'h0001, "continuous second");
        reg_write(8'h22, 8'h07);
        frame_pulse(n);
        check(n[15:0], 16'h0000, "target none continuous");
        reg_write(8'h22, 8'h0b);
        frame_pulse(n);
        check(n[15:0], 16'h0000, "target none one-shot");
        check({15'h0000, frame_armed_o}, 16'h0000, "arm consumed");
        reg_write(8'h22, 8'h0a);
        frame_pulse(n);
        check(n[15:0], 16'h0001, "fifo target again");
        $display("test frame reset done");

        tally_and_finish();
    end
endmodule
`default_nettype wire
